/* File: hw/ltssc_pkg.sv */
package ltssc_pkg;

    // Register offsets.
    localparam logic [7:0] REG_SPREAD = 8'h02;
    localparam logic [7:0] REG_SAWTOOTH_DIVIDER = 8'h03;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_DRIVE = 8'h05;

    // Field positions and widths.
    localparam int SAWTOOTH_DIVIDER_W = 6;
    localparam int DRIVE_W = 4;
    localparam int SS_SER_W = 3;
    localparam int SS_DES_W = 2;
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_MCLK_BIT = 7;

    // Reset and pin-selected default values, and drive code limits.
    localparam logic [3:0] EQ_DEF_HIGH = 4'h4;
    localparam logic [3:0] EQ_DEF_LOW = 4'h9;
    localparam logic [3:0] EQ_MAX = 4'hB;
    localparam logic [3:0] EMPH_NONE = 4'h0;
    localparam logic [3:0] EMPH_DEEMPH_MAX = 4'h4;
    localparam logic [2:0] SS_SER_DEF_ON = 3'h1;
    localparam logic [1:0] SS_DES_DEF_ON = 2'h1;
    localparam logic [SAWTOOTH_DIVIDER_W-1:0] SAWTOOTH_DIVIDER_RESET = 6'h00;

    // Timing.
    localparam int CLK_FREQ_MHZ = 200;
    localparam int CLK_FREQ_HZ = CLK_FREQ_MHZ * 1000000;
    localparam int SLEEP_WAIT_US = 8000;
    localparam int SLEEP_WAIT_CYC = SLEEP_WAIT_US * CLK_FREQ_MHZ;
    localparam int MOD_FREQ_TARGET_HZ = 30000;
    localparam int AUTO_PERIOD_CYC = CLK_FREQ_HZ / MOD_FREQ_TARGET_HZ;

    // Modulation coefficients.
    localparam logic [7:0] MOD_SER24_LOW = 8'h50;
    localparam logic [7:0] MOD_SER24_MID = 8'h70;
    localparam logic [7:0] MOD_SER24_HIGH = 8'h98;
    localparam logic [7:0] MOD_SER32_LOW = 8'h68;
    localparam logic [7:0] MOD_SER32_MID = 8'h98;
    localparam logic [7:0] MOD_SER32_HIGH = 8'hCC;
    localparam logic [7:0] MOD_DES = 8'hD0;

    typedef enum logic [2:0] {
        RATE_NONE, RATE_0P5, RATE_1, RATE_1P5, RATE_2, RATE_3, RATE_4
    } ltssc_rate_t;

    typedef enum {
        S_AWAKE, S_SLEEP_WAIT, S_ASLEEP, S_WAKING
    } ltssc_sleep_t;

    // Straps captured when leaving reset or power-down.
    typedef struct packed {
        logic eqDefault;
        logic spreadDefault;
        logic rateRange;
        logic autostart;
    } ltssc_strap_t;

endpackage

/* File: hw/ltssc_pin_sync.sv */
`timescale 1ns/1ps
module ltssc_pin_sync import ltssc_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Pins.
    input wire logic [W-1:0] pinAsync,
    output logic [W-1:0] pinSync
);

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= pinAsync;
            stage2_reg <= stage1_reg;
        end
    end

    assign pinSync = stage2_reg;

endmodule

/* File: hw/ltssc_sawtooth.sv */
`timescale 1ns/1ps
module ltssc_sawtooth import ltssc_pkg::*; #(
    parameter int PERIOD_W = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Control.
    input wire logic enable,
    input wire logic [PERIOD_W-1:0] periodCycles,
    // Modulation.
    output logic modTick,
    output logic [PERIOD_W-1:0] modPhase
);

    logic [PERIOD_W-1:0] count_reg;
    logic [PERIOD_W-1:0] count_next;
    logic tick_reg;
    logic tick_next;

    // One sawtooth ramp per period; a new period value takes effect at once, as the count is compared with it every cycle.
    always_comb begin
        count_next = count_reg;
        tick_next = 1'b0;
        if (!enable) begin
            count_next = '0;
        end else if (count_reg >= periodCycles - PERIOD_W'(1)) begin
            count_next = '0;
            tick_next = 1'b1;
        end else begin
            count_next = count_reg + PERIOD_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign modTick = tick_reg;
    assign modPhase = count_reg;

endmodule

/* File: hw/ltssc_ctrl.sv */
`timescale 1ns/1ps
module ltssc_ctrl import ltssc_pkg::*; #(
    parameter bit IS_SERIALIZER = 1'b1,
    parameter bit IS_UC_SIDE = 1'b1,
    parameter bit BUS_32 = 1'b0,
    parameter int SLEEP_WAIT_CYCLES = SLEEP_WAIT_CYC,
    parameter int PERIOD_W = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Register port.
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Pins.
    input wire logic powerdown_pin_n,
    input wire logic eq_default_select_pin,
    input wire logic spread_default_pin,
    input wire logic rate_range_pin,
    input wire logic autostart_pin,
    // Link status.
    input wire logic linkActive,
    input wire logic linkLocked,
    input wire logic wakeDetect,
    // Settings and status.
    output logic [3:0] driveCode,
    output ltssc_rate_t spreadRate,
    output logic linkRestart,
    output logic linkAvailable,
    output logic audioFollowsSpread,
    output logic sleeping,
    output logic protectReset,
    output logic powerDown,
    output logic autostartLatched,
    output logic modTick
);

    localparam int TW = $clog2(SLEEP_WAIT_CYCLES + 1);

    logic [7:0] pinsSync;
    logic pdnSync;
    logic intRst;
    ltssc_strap_t strapNow;

    ltssc_pin_sync #(.W(8)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinAsync({powerdown_pin_n, eq_default_select_pin, spread_default_pin,
                   rate_range_pin, autostart_pin, linkActive, linkLocked, wakeDetect}),
        .pinSync(pinsSync)
    );

    assign pdnSync = pinsSync[7];
    assign strapNow = ltssc_strap_t'(pinsSync[6:3]);
    // Power-down acts as a reset of everything behind the synchronisers except the powerDown output register.
    assign intRst = rst | ~pdnSync;

    function automatic logic driveLegal(input logic [3:0] code);
        if (IS_SERIALIZER) begin
            driveLegal = (code <= EMPH_DEEMPH_MAX) || code[3];
        end else begin
            driveLegal = (code <= EQ_MAX);
        end
    endfunction

    function automatic ltssc_rate_t decodeSpread(input logic [2:0] code);
        if (IS_SERIALIZER) begin
            unique case (code)
                3'h1: decodeSpread = RATE_0P5;
                3'h2: decodeSpread = RATE_1P5;
                3'h3: decodeSpread = RATE_2;
                3'h5: decodeSpread = RATE_1;
                3'h6: decodeSpread = RATE_3;
                3'h7: decodeSpread = RATE_4;
                default: decodeSpread = RATE_NONE;
            endcase
        end else begin
            unique case (code[1:0])
                2'h1: decodeSpread = RATE_2;
                2'h3: decodeSpread = RATE_4;
                default: decodeSpread = RATE_NONE;
            endcase
        end
    endfunction

    function automatic logic [7:0] modCoef(input ltssc_rate_t rate);
        if (!IS_SERIALIZER) begin
            modCoef = MOD_DES;
        end else if (rate == RATE_0P5 || rate == RATE_1) begin
            modCoef = BUS_32 ? MOD_SER32_LOW : MOD_SER24_LOW;
        end else if (rate == RATE_1P5 || rate == RATE_3) begin
            modCoef = BUS_32 ? MOD_SER32_MID : MOD_SER24_MID;
        end else begin
            modCoef = BUS_32 ? MOD_SER32_HIGH : MOD_SER24_HIGH;
        end
    endfunction

    // Configuration registers and strap capture.
    logic strapPending_reg, strapPending_next;
    logic strapLoad;
    ltssc_strap_t strap_reg, strap_next;
    logic [3:0] drive_reg, drive_next;
    logic [2:0] spreadCode_reg, spreadCode_next;
    logic [SAWTOOTH_DIVIDER_W-1:0] sawtooth_divider_reg, sawtooth_divider_next;
    logic audio_clock_source_sel_reg, audio_clock_source_sel_next;
    logic sleepBit_reg, sleepBit_next;
    logic wrSpread, wrCtrl;
    logic spreadOnOld, spreadOnNew;
    logic lockClear;

    assign strapLoad = strapPending_reg;
    assign wrSpread = regWrEn && regAddr == REG_SPREAD;
    assign wrCtrl = regWrEn && regAddr == REG_CTRL;

    always_comb begin
        strapPending_next = 1'b0;
        strap_next = strap_reg;
        drive_next = drive_reg;
        spreadCode_next = spreadCode_reg;
        sawtooth_divider_next = sawtooth_divider_reg;
        audio_clock_source_sel_next = audio_clock_source_sel_reg;
        sleepBit_next = sleepBit_reg;
        if (strapLoad) begin
            strap_next = strapNow;
            if (!IS_SERIALIZER) begin
                drive_next = strapNow.eqDefault ? EQ_DEF_HIGH : EQ_DEF_LOW;
            end
            if (strapNow.spreadDefault) begin
                spreadCode_next = IS_SERIALIZER ? SS_SER_DEF_ON : {1'b0, SS_DES_DEF_ON};
            end
        end
        if (regWrEn && regAddr == REG_DRIVE && driveLegal(regWrData[3:0])) begin
            drive_next = regWrData[DRIVE_W-1:0];
        end
        if (wrSpread) begin
            spreadCode_next = IS_SERIALIZER ? regWrData[2:0] : {1'b0, regWrData[1:0]};
        end
        if (regWrEn && regAddr == REG_SAWTOOTH_DIVIDER) begin
            sawtooth_divider_next = regWrData[SAWTOOTH_DIVIDER_W-1:0];
        end
        if (wrCtrl) begin
            audio_clock_source_sel_next = regWrData[CTRL_MCLK_BIT];
        end
        if (lockClear) begin
            sleepBit_next = 1'b0;
        end
        if (wrCtrl && !IS_UC_SIDE) begin
            if (regWrData[CTRL_SLEEP_BIT] || !lockClear) begin
                sleepBit_next = regWrData[CTRL_SLEEP_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (intRst) begin
            strapPending_reg <= 1'b1;
            strap_reg <= '0;
            drive_reg <= EMPH_NONE;
            spreadCode_reg <= 3'h0;
            sawtooth_divider_reg <= SAWTOOTH_DIVIDER_RESET;
            audio_clock_source_sel_reg <= 1'b0;
            sleepBit_reg <= 1'b0;
        end else begin
            strapPending_reg <= strapPending_next;
            strap_reg <= strap_next;
            drive_reg <= drive_next;
            spreadCode_reg <= spreadCode_next;
            sawtooth_divider_reg <= sawtooth_divider_next;
            audio_clock_source_sel_reg <= audio_clock_source_sel_next;
            sleepBit_reg <= sleepBit_next;
        end
    end

    // Sleep sequencing.
    ltssc_sleep_t sleep_reg, sleep_next;
    logic [TW-1:0] timer_reg, timer_next;
    logic timerDone;

    assign timerDone = timer_reg >= TW'(SLEEP_WAIT_CYCLES - 1);
    assign lockClear = sleep_reg == S_WAKING && pinsSync[1];

    always_comb begin
        sleep_next = sleep_reg;
        timer_next = '0;
        unique case (sleep_reg)
            S_AWAKE: begin
                if (sleepBit_reg) begin
                    sleep_next = IS_SERIALIZER ? S_ASLEEP : S_SLEEP_WAIT;
                end
            end
            S_SLEEP_WAIT: begin
                timer_next = timer_reg + TW'(1);
                if (!sleepBit_reg) begin
                    sleep_next = S_AWAKE;
                end else if (!pinsSync[2] || timerDone) begin
                    sleep_next = S_ASLEEP;
                end
            end
            S_ASLEEP: begin
                if (!sleepBit_reg) begin
                    sleep_next = S_AWAKE;
                end else if (!IS_SERIALIZER && pinsSync[0]) begin
                    sleep_next = S_WAKING;
                end
            end
            S_WAKING: begin
                timer_next = timer_reg + TW'(1);
                if (pinsSync[1]) begin
                    sleep_next = S_AWAKE;
                end else if (timerDone) begin
                    sleep_next = S_ASLEEP;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (intRst) begin
            sleep_reg <= S_AWAKE;
            timer_reg <= '0;
        end else begin
            sleep_reg <= sleep_next;
            timer_reg <= timer_next;
        end
    end

    // Link restart on serializer spread on/off change.
    logic restart_reg, restart_next;
    logic waitLock_reg, waitLock_next;
    logic sawUnlock_reg, sawUnlock_next;

    assign spreadOnOld = decodeSpread(spreadCode_reg) != RATE_NONE;
    assign spreadOnNew = decodeSpread(spreadCode_next) != RATE_NONE;

    always_comb begin
        restart_next = IS_SERIALIZER && wrSpread && (spreadOnOld != spreadOnNew);
        waitLock_next = waitLock_reg;
        sawUnlock_next = sawUnlock_reg;
        if (restart_next) begin
            waitLock_next = 1'b1;
            sawUnlock_next = 1'b0;
        end else if (waitLock_reg) begin
            if (!pinsSync[1]) begin
                sawUnlock_next = 1'b1;
            end else if (sawUnlock_reg) begin
                waitLock_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (intRst) begin
            restart_reg <= 1'b0;
            waitLock_reg <= 1'b0;
            sawUnlock_reg <= 1'b0;
        end else begin
            restart_reg <= restart_next;
            waitLock_reg <= waitLock_next;
            sawUnlock_reg <= sawUnlock_next;
        end
    end

    // Modulation period: coefficient times divider, halved by the rate pin.
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] manualPeriod;
    logic spreadOn;
    logic tick;

    assign spreadOn = decodeSpread(spreadCode_reg) != RATE_NONE;
    assign manualPeriod = PERIOD_W'(({8'h00, modCoef(decodeSpread(spreadCode_reg))}
                                     * {10'h000, sawtooth_divider_reg}) >> strap_reg.rateRange);
    // A zero divider selects auto mode, which pins the rate near 30 kHz.
    assign period = (sawtooth_divider_reg == '0) ? PERIOD_W'(AUTO_PERIOD_CYC) : manualPeriod;

    ltssc_sawtooth #(.PERIOD_W(PERIOD_W)) u_saw (
        .clk_sys(clk_sys),
        .rst(intRst),
        .enable(spreadOn && sleep_reg == S_AWAKE),
        .periodCycles(period),
        .modTick(tick),
        .modPhase()
    );

    // Registered outputs and read-back.
    logic [7:0] rdData_next;
    logic prevAsleep_reg;
    logic protect_reg, protect_next;

    always_comb begin
        unique case (regAddr)
            REG_SPREAD: rdData_next = {5'h00, spreadCode_reg};
            REG_SAWTOOTH_DIVIDER: rdData_next = {2'h0, sawtooth_divider_reg};
            REG_CTRL: rdData_next = {audio_clock_source_sel_reg, 6'h00, sleepBit_reg};
            REG_DRIVE: rdData_next = {4'h0, drive_reg};
            default: rdData_next = 8'h00;
        endcase
        protect_next = sleep_next == S_ASLEEP && sleep_reg != S_ASLEEP;
    end

    always_ff @(posedge clk_sys) begin
        if (intRst) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
            driveCode <= EMPH_NONE;
            spreadRate <= RATE_NONE;
            linkRestart <= 1'b0;
            linkAvailable <= 1'b0;
            audioFollowsSpread <= 1'b0;
            sleeping <= 1'b0;
            protect_reg <= 1'b0;
            prevAsleep_reg <= 1'b0;
            autostartLatched <= 1'b0;
            modTick <= 1'b0;
        end else begin
            regRdData <= regRdEn ? rdData_next : 8'h00;
            regRdValid <= regRdEn;
            driveCode <= drive_reg;
            spreadRate <= decodeSpread(spreadCode_reg);
            linkRestart <= restart_reg;
            linkAvailable <= !waitLock_reg && !restart_reg;
            audioFollowsSpread <= IS_SERIALIZER ? spreadOn : !audio_clock_source_sel_reg;
            sleeping <= sleep_reg == S_ASLEEP || sleep_reg == S_WAKING;
            protect_reg <= protect_next;
            prevAsleep_reg <= sleep_reg == S_ASLEEP;
            autostartLatched <= strap_reg.autostart;
            modTick <= tick;
        end
    end

    assign protectReset = protect_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            powerDown <= 1'b1;
        end else begin
            powerDown <= !pdnSync;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (intRst);

    sequence wakeThenLock;
        sleep_reg == S_WAKING ##1 sleep_reg == S_AWAKE;
    endsequence

    chk_eq_range: assert property (!IS_SERIALIZER |-> drive_reg <= EQ_MAX)
        else $error("Boost code out of range.");
    chk_eq_default: assert property (!IS_SERIALIZER && strapLoad |=>
        drive_reg == ($past(strapNow.eqDefault) ? EQ_DEF_HIGH : EQ_DEF_LOW)
        || $past(regWrEn)) else $error("Boost default wrong.");
    chk_strap_hold: assert property (!strapLoad |=> strap_reg == $past(strap_reg))
        else $error("Strap changed outside capture.");
    chk_emph_legal: assert property (IS_SERIALIZER |-> drive_reg <= EMPH_DEEMPH_MAX
        || drive_reg[3]) else $error("Illegal emphasis code.");
    chk_spread_default: assert property (strapLoad && !strapNow.spreadDefault
        && !regWrEn |=> spreadCode_reg == 3'h0) else $error("Spread default wrong.");
    chk_restart_gap: assert property (restart_reg |=> !linkAvailable ##1 !linkAvailable)
        else $error("Link available during restart.");
    chk_mclk_follow: assert property (!IS_SERIALIZER && audio_clock_source_sel_reg ##1 audio_clock_source_sel_reg
        |=> !audioFollowsSpread) else $error("Audio clock follows spread.");
    chk_sleep_refuse: assert property (IS_UC_SIDE |-> !sleepBit_reg)
        else $error("Controller side took sleep.");
    chk_sleep_timeout: assert property (sleep_reg == S_SLEEP_WAIT |->
        timer_reg < TW'(SLEEP_WAIT_CYCLES)) else $error("Sleep wait overran.");
    chk_wake_clear: assert property (wakeThenLock |-> !sleepBit_reg)
        else $error("Sleep bit kept after lock.");
    chk_protect_pulse: assert property ($rose(prevAsleep_reg) && $past(sleep_reg) != S_WAKING
        |-> $past(protect_reg) || protect_reg) else $error("No protect reset.");

endmodule

/* File: dv/ltssc_uc_model.sv */
`timescale 1ns/1ps
module ltssc_uc_model import ltssc_pkg::*; (
    // Clock.
    input wire logic clk_sys,
    // Strobes per device, bit 0 serializer, bit 1 deserializer.
    output logic [1:0] wrEn,
    output logic [1:0] rdEn,
    // Shared address and data.
    output logic [7:0] addr,
    output logic [7:0] wrData
);
    logic [1:0] spreadOn = 2'h0;
    initial {wrEn, rdEn, addr, wrData} = 20'h00000;
    task automatic wr(input logic [1:0] sel, input logic [7:0] a, input logic [7:0] d);
        logic [1:0] on;
        on = spreadOn;
        if (a == 8'h02) begin
            if (sel[0]) on[0] = !(d[2:0] inside {3'h0, 3'h4});
            if (sel[1]) on[1] = d[0];
            // Only the smallest serializer rate suits this fast pixel clock.
            if (sel[0] && on[0] && d[2:0] != 3'h1) return;
            if (on == 2'h3) return;
            spreadOn = on;
        end
        @(posedge clk_sys);
        #1 wrEn = sel;
        addr = a;
        wrData = d;
        @(posedge clk_sys);
        #1 wrEn = 2'h0;
    endtask
    task automatic rd(input logic [1:0] sel, input logic [7:0] a);
        @(posedge clk_sys);
        #1 rdEn = sel;
        addr = a;
        @(posedge clk_sys);
        #1 rdEn = 2'h0;
    endtask
    // A divider above the table limit is clamped to the limit.
    task automatic setDivider(input int want);
        wr(2'h3, 8'h03, 8'((want > 32'h3F) ? 32'h3F : want));
    endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top import ltssc_pkg::*;;
    localparam int WAITC = 50;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic pdN = 1'b1, eqPin = 1'b1, ssPin = 1'b1, ratePin = 1'b0, autoPin = 1'b1;
    logic active = 1'b1, locked = 1'b1, wake = 1'b0;
    logic [1:0] wrEn, rdEn, rdV, restart, avail, audio, sleepy, prot, pd, autoL, tick;
    logic [7:0] addr, wrData, d;
    logic [7:0] rdData [2];
    logic [3:0] drv [2];
    ltssc_rate_t rate [2];
    logic [3:0] e0, e1;
    logic remSleep;
    int fails = 0, compares = 0, seed = 32'h22d3, nRestart = 0, nProt = 0, n;
    ltssc_rate_t desTab [4] = '{RATE_NONE, RATE_2, RATE_NONE, RATE_4};
    ltssc_rate_t serTab [4] = '{RATE_0P5, RATE_NONE, RATE_0P5, RATE_NONE};
    logic [2:0] serCode [4] = '{3'h1, 3'h4, 3'h1, 3'h0};
    initial forever #2.5 clk_sys = ~clk_sys;
    ltssc_uc_model u_uc (.clk_sys(clk_sys), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
        .wrData(wrData));
    for (genvar i = 0; i < 2; i++) begin : g
        ltssc_ctrl #(.IS_SERIALIZER(i == 0), .IS_UC_SIDE(i == 0),
            .SLEEP_WAIT_CYCLES(WAITC)) u_dut (
            .clk_sys(clk_sys), .rst(rst), .regWrEn(wrEn[i]), .regRdEn(rdEn[i]),
            .regAddr(addr), .regWrData(wrData), .regRdData(rdData[i]), .regRdValid(rdV[i]),
            .powerdown_pin_n(pdN), .eq_default_select_pin(eqPin),
            .spread_default_pin(ssPin), .rate_range_pin(ratePin), .autostart_pin(autoPin),
            .linkActive(active), .linkLocked(locked), .wakeDetect(wake),
            .driveCode(drv[i]), .spreadRate(rate[i]), .linkRestart(restart[i]),
            .linkAvailable(avail[i]), .audioFollowsSpread(audio[i]), .sleeping(sleepy[i]),
            .protectReset(prot[i]), .powerDown(pd[i]), .autostartLatched(autoL[i]),
            .modTick(tick[i]));
    end
    // A remote serializer shares the serializer strobe so that its own sleep path is exercised.
    if (1) begin : gRem
        ltssc_ctrl #(.IS_SERIALIZER(1'b1), .IS_UC_SIDE(1'b0), .SLEEP_WAIT_CYCLES(WAITC)) u_dut (
            .clk_sys(clk_sys), .rst(rst), .regWrEn(wrEn[0]), .regRdEn(1'b0), .regAddr(addr),
            .regWrData(wrData), .regRdData(), .regRdValid(), .powerdown_pin_n(pdN),
            .eq_default_select_pin(eqPin), .spread_default_pin(ssPin), .rate_range_pin(ratePin),
            .autostart_pin(autoPin), .linkActive(active), .linkLocked(locked), .wakeDetect(wake),
            .driveCode(), .spreadRate(), .linkRestart(), .linkAvailable(),
            .audioFollowsSpread(), .sleeping(remSleep), .protectReset(), .powerDown(),
            .autostartLatched(), .modTick());
    end
    always @(posedge clk_sys) begin
        if (restart[0] === 1'b1) nRestart++;
        if (prot[1] === 1'b1) nProt++;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic chkRd(input logic [1:0] sel, input logic [7:0] a, input logic [7:0] e);
        u_uc.rd(sel, a);
        `CHK(rdV, sel)
        for (int i = 0; i < 2; i++) if (sel[i]) `CHK(rdData[i], e)
    endtask
    // Finds one tick, then counts the cycles up to the next one; n + 1 is the period.
    task automatic waitTick();
        for (int k = 0; k < 2; k++) begin
            n = 0;
            if (k == 1) cyc(1);
            while (tick[0] !== 1'b1 && n < 20000) begin
                cyc(1);
                n++;
            end
        end
    endtask
    task automatic complete_run();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 rst = 1'b0;
        cyc(2);
        chkRd(2'h2, 8'h05, {4'h0, EQ_DEF_HIGH});
        chkRd(2'h3, 8'h02, 8'h01);
        `CHK(autoL, 2'h3)
        eqPin = 1'b0;
        ssPin = 1'b0;
        autoPin = 1'b0;
        cyc(6);
        chkRd(2'h2, 8'h05, 8'h04);
        chkRd(2'h3, 8'h02, 8'h01);
        pdN = 1'b0;
        cyc(6);
        `CHK(pd, 2'h3)
        pdN = 1'b1;
        cyc(6);
        `CHK(pd, 2'h0)
        u_uc.spreadOn = 2'h0;
        chkRd(2'h2, 8'h05, {4'h0, EQ_DEF_LOW});
        chkRd(2'h3, 8'h02, 8'h00);
        `CHK(autoL, 2'h0)
        $display("test straps and power-down done");
        u_uc.wr(2'h3, 8'h04, 8'h01);
        cyc(2);
        `CHK(remSleep, 1'b1)
        n = 0;
        while (sleepy[1] !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        `CHK(n >= WAITC - 4 && n <= WAITC + 4, 1'b1)
        `CHK(nProt, 1)
        `CHK(sleepy[0], 1'b0)
        chkRd(2'h1, 8'h04, 8'h00);
        chkRd(2'h2, 8'h05, 8'h09);
        locked = 1'b0;
        wake = 1'b1;
        cyc(4);
        wake = 1'b0;
        locked = 1'b1;
        cyc(8);
        `CHK(sleepy[1], 1'b0)
        chkRd(2'h2, 8'h04, 8'h00);
        active = 1'b0;
        u_uc.wr(2'h2, 8'h04, 8'h01);
        cyc(8);
        `CHK(sleepy[1], 1'b1)
        locked = 1'b0;
        wake = 1'b1;
        cyc(4);
        wake = 1'b0;
        cyc(WAITC + 10);
        chkRd(2'h2, 8'h04, 8'h01);
        `CHK(sleepy[1], 1'b1)
        active = 1'b1;
        locked = 1'b1;
        u_uc.wr(2'h2, 8'h04, 8'h80);
        cyc(3);
        `CHK({audio[1], sleepy[1]}, 2'h0)
        u_uc.wr(2'h2, 8'h04, 8'h00);
        cyc(3);
        `CHK(audio[1], 1'b1)
        $display("test sleep done");
        u_uc.wr(2'h3, 8'h05, 8'h00);
        e0 = 4'h0;
        e1 = 4'h0;
        repeat (40) begin
            d = 8'($random(seed));
            u_uc.wr(2'h3, 8'h05, d);
            if (d[3:0] <= EQ_MAX) e1 = d[3:0];
            if (!(d[3:0] inside {4'h5, 4'h6, 4'h7})) e0 = d[3:0];
            chkRd(2'h1, 8'h05, {4'h0, e0});
            `CHK(drv[0], e0)
            chkRd(2'h2, 8'h05, {4'h0, e1});
            `CHK(drv[1], e1)
        end
        for (int c = 0; c < 4; c++) begin
            u_uc.wr(2'h2, 8'h02, 8'hFC | 8'(c));
            chkRd(2'h2, 8'h02, 8'(c));
            `CHK(rate[1], desTab[c])
        end
        u_uc.wr(2'h2, 8'h02, 8'h00);
        for (int c = 0; c < 4; c++) begin
            n = nRestart;
            u_uc.wr(2'h1, 8'h02, {5'h00, serCode[c]});
            cyc(4);
            `CHK(rate[0], serTab[c])
            `CHK({nRestart - n, avail[0]}, {32'h1, 1'b0})
            locked = 1'b0;
            cyc(5);
            locked = 1'b1;
            cyc(6);
            `CHK(avail[0], 1'b1)
        end
        $display("test codes done");
        u_uc.wr(2'h1, 8'h02, 8'h01);
        waitTick();
        `CHK(n + 1, AUTO_PERIOD_CYC)
        u_uc.setDivider(100);
        chkRd(2'h3, 8'h03, 8'h3F);
        `CHK(audio[0], 1'b1)
        waitTick();
        `CHK(n + 1, MOD_SER24_LOW * 63)
        $display("test modulation done");
        complete_run();
    end
endmodule
